// *** hw/sprx_top.sv ***
// sprx_top.sv: receive path of the serial port, all three modes
// assumes: config held stable while enabled; time base is a slow free-running pin clock
`default_nettype none
`include "sprx_regs.svh"

module sprx_top #(
   parameter int SYNC_STAGES = 3,
   parameter int DATA_W      = 8
) (
   input  wire logic                  SYS_CLK,
   input  wire logic                  RST,
   input  wire sprx_pkg::sprx_cfg_t   RX_CFG,
   input  wire logic                  RX_ENABLE_WR,
   input  wire logic                  RX_ENABLE_WDATA,
   input  wire logic                  STATUS_RD,
   input  wire logic                  RX_BUF_RD,
   input  wire logic                  TIME_BASE_CLK,
   input  wire logic                  TIMER_OVF,
   input  wire logic                  RXD,
   input  wire logic                  RX_SHIFT_CLK_IN,
   output logic                       RX_SHIFT_CLK_OUT,
   output logic                       RX_SHIFT_CLK_OE,
   output logic                       RX_ENABLE,
   output logic [DATA_W-1:0]          RX_DATA,
   output logic                       RX_FULL,
   output sprx_pkg::sprx_stat_t       RX_STATUS,
   output logic                       RX_IRQ,
   output logic                       RX_BUSY
);

   // ****************************************
   // elaboration checks
   // ****************************************
   // fewer stages break the agree-on-two-flops filter
   if (SYNC_STAGES != 3) begin : g_chk_sync
      $error("SYNC_STAGES must be 3");
   end
   if (DATA_W != 8) begin : g_chk_w
      $error("DATA_W must be 8");
   end

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [8:0] set_bit(input logic [8:0] v, input logic [3:0] i,
                                          input logic b);
      logic [8:0] r;
      r = v;
      r[i] = b;
      return r;
   endfunction

   function automatic logic [7:0] assemble(input logic [8:0] raw, input logic [3:0] n,
                                           input logic msb);
      logic [7:0] o;
      o = 8'h00;
      for (int i = 0; i < 8; i++) begin
         if (4'(i) < n) begin
            if (msb) begin
               o[7-i] = raw[i];
            end else begin
               o[i] = raw[i];
            end
         end
      end
      return o;
   endfunction

   function automatic logic par_bad(input logic [8:0] raw, input logic [3:0] n,
                                    input logic odd);
      logic x;
      x = raw[n];
      for (int i = 0; i < 8; i++) begin
         if (4'(i) < n) begin
            x = x ^ raw[i];
         end
      end
      return x ^ odd;
   endfunction

   // ****************************************
   // pin synchronisers, three flops, accept when stages 2 and 3 agree
   // ****************************************
   logic [2:0] tb_sy_r;
   logic [2:0] rxd_sy_r;
   logic [2:0] tog_sy_r;
   logic       tb_lvl_r;
   logic       tb_prev_r;
   logic       rxd_lvl_r;
   logic       rxd_prev_r;
   logic       half_r;
   logic       tog_l_r;

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         tb_sy_r    <= 3'h0;
         rxd_sy_r   <= 3'h7;
         tog_sy_r   <= 3'h0;
         tb_lvl_r   <= 1'b0;
         tb_prev_r  <= 1'b0;
         rxd_lvl_r  <= 1'b1;
         rxd_prev_r <= 1'b1;
      end else begin
         tb_sy_r    <= {tb_sy_r[1:0], TIME_BASE_CLK};
         rxd_sy_r   <= {rxd_sy_r[1:0], RXD};
         tog_sy_r   <= {tog_sy_r[1:0], tog_l_r};
         tb_prev_r  <= tb_lvl_r;
         rxd_prev_r <= rxd_lvl_r;
         if (tb_sy_r[1] == tb_sy_r[2]) begin
            tb_lvl_r <= tb_sy_r[2];
         end
         if (rxd_sy_r[1] == rxd_sy_r[2]) begin
            rxd_lvl_r <= rxd_sy_r[2];
         end
      end
   end

   // ****************************************
   // mode decode and rate ticks
   // ****************************************
   wire logic       m_uart  = ~RX_CFG.mode_sync;
   wire logic       m_int   = RX_CFG.mode_sync & RX_CFG.clk_internal;
   wire logic       m_ext   = RX_CFG.mode_sync & ~RX_CFG.clk_internal;
   wire logic       tb_rise = tb_lvl_r & ~tb_prev_r;
   wire logic       tb_fall = ~tb_lvl_r & tb_prev_r;
   wire logic       rxd_fall = ~rxd_lvl_r & rxd_prev_r;
   // uart ticks come from slow time base edges sampled on SYS_CLK, or from TIMER_OVF at the timer rate
   wire logic       baud_tick =
      (RX_CFG.rate == `SPRX_RATE_X2)   ? (tb_rise | tb_fall) :
      (RX_CFG.rate == `SPRX_RATE_X1)   ? tb_rise :
      (RX_CFG.rate == `SPRX_RATE_HALF) ? (tb_rise & half_r) : TIMER_OVF;
   wire logic [3:0] n_data  = `SPRX_LEN_BASE + {2'h0, RX_CFG.len};
   wire logic [3:0] n_sync  = n_data + {3'h0, RX_CFG.par_en};
   wire logic [3:0] u_last  = n_sync + 4'h1 + {3'h0, RX_CFG.stop_two};

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         half_r <= 1'b0;
      end else if (tb_rise) begin
         half_r <= ~half_r;
      end
   end

   // ****************************************
   // link domain: external shift clock
   // ****************************************
   // config is read here unsynchronised; it must not change while enabled
   logic [3:0] cnt_l_r;
   logic [8:0] raw_l_r;
   logic [8:0] hold_l_r;
   wire logic  last_l = (cnt_l_r == n_sync - 4'h1);
   wire logic [8:0] raw_l_nxt = set_bit(raw_l_r, cnt_l_r, RXD);

   always_ff @(posedge RX_SHIFT_CLK_IN or posedge RST) begin
      if (RST) begin
         cnt_l_r  <= 4'h0;
         raw_l_r  <= 9'h000;
         hold_l_r <= 9'h000;
         tog_l_r  <= 1'b0;
      end else begin
         raw_l_r <= raw_l_nxt;
         if (last_l) begin
            hold_l_r <= raw_l_nxt;
            tog_l_r  <= ~tog_l_r;
            cnt_l_r  <= 4'h0;
         end else begin
            cnt_l_r <= cnt_l_r + 4'h1;
         end
      end
   end

   // hold word is stable for a whole frame after the toggle, so it is taken as is
   wire logic ext_ev = tog_sy_r[1] ^ tog_sy_r[2];

   // ****************************************
   // receive sequencer
   // ****************************************
   sprx_pkg::sprx_state_t st_r, st_nxt;
   logic [3:0] pos_r, pos_nxt;
   logic [8:0] raw_r, raw_nxt;
   logic       framing_error_flag_r, framing_error_flag_nxt;
   logic       done_r;
   logic       done_nxt;
   logic       sck_r;
   logic       en_r;
   logic       irq_r;
   logic       sync_r;

   wire logic can_start = en_r & ~done_r & ~irq_r;

   always_comb begin
      st_nxt   = st_r;
      pos_nxt  = pos_r;
      raw_nxt  = raw_r;
      framing_error_flag_nxt = framing_error_flag_r;
      done_nxt = 1'b0;
      unique case (st_r)
         sprx_pkg::SPRX_IDLE: begin
            pos_nxt = 4'h0;
            if (can_start & m_uart & rxd_fall) begin
               st_nxt   = sprx_pkg::SPRX_UART;
               framing_error_flag_nxt = 1'b0;
            end else if (can_start & m_int) begin
               st_nxt = sprx_pkg::SPRX_WAIT;
            end else if (can_start & m_ext) begin
               st_nxt = sprx_pkg::SPRX_EXT;
            end
         end
         sprx_pkg::SPRX_UART: begin
            if (!en_r) begin
               st_nxt = sprx_pkg::SPRX_IDLE;
            end else if (baud_tick) begin
               pos_nxt = pos_r + 4'h1;
               if (pos_r == 4'h0) begin
                  framing_error_flag_nxt = framing_error_flag_r | rxd_lvl_r;
               end else if (pos_r <= n_sync) begin
                  raw_nxt = set_bit(raw_r, pos_r - 4'h1, rxd_lvl_r);
               end else begin
                  framing_error_flag_nxt = framing_error_flag_r | ~rxd_lvl_r;
               end
               if (pos_r == u_last) begin
                  st_nxt   = sprx_pkg::SPRX_IDLE;
                  done_nxt = 1'b1;
               end
            end
         end
         sprx_pkg::SPRX_WAIT: begin
            if (!en_r) begin
               st_nxt = sprx_pkg::SPRX_IDLE;
            end else if (tb_rise) begin
               pos_nxt = pos_r + 4'h1;
               if (pos_r[1:0] == `SPRX_START_WAIT) begin
                  st_nxt  = sprx_pkg::SPRX_SHIFT;
                  pos_nxt = 4'h0;
               end
            end
         end
         sprx_pkg::SPRX_SHIFT: begin
            if (!en_r) begin
               st_nxt = sprx_pkg::SPRX_IDLE;
            end else if (tb_rise) begin
               raw_nxt = set_bit(raw_r, pos_r, rxd_lvl_r);
               pos_nxt = pos_r + 4'h1;
               if (pos_r == n_sync - 4'h1) begin
                  st_nxt   = sprx_pkg::SPRX_IDLE;
                  done_nxt = 1'b1;
               end
            end
         end
         sprx_pkg::SPRX_EXT: begin
            if (!en_r) begin
               st_nxt = sprx_pkg::SPRX_IDLE;
            end else if (ext_ev) begin
               raw_nxt  = hold_l_r;
               framing_error_flag_nxt = 1'b0;
               st_nxt   = sprx_pkg::SPRX_IDLE;
               done_nxt = 1'b1;
            end
         end
         default: begin
            st_nxt = sprx_pkg::SPRX_IDLE;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         st_r   <= sprx_pkg::SPRX_IDLE;
         pos_r  <= 4'h0;
         raw_r  <= 9'h000;
         framing_error_flag_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         st_r   <= st_nxt;
         pos_r  <= pos_nxt;
         raw_r  <= raw_nxt;
         framing_error_flag_r <= framing_error_flag_nxt;
         done_r <= done_nxt;
      end
   end

   // ****************************************
   // shift clock output, internal mode only
   // ****************************************
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         sck_r <= 1'b1;
      end else begin
         sck_r <= (st_r == sprx_pkg::SPRX_SHIFT) ? tb_lvl_r : 1'b1;
      end
   end

   // ****************************************
   // frame completion: buffer, flags, request, enable
   // ****************************************
   logic [7:0]           buf_r;
   logic                 full_r;
   sprx_pkg::sprx_stat_t stat_r;

   wire logic       ovr       = done_r & full_r;
   wire logic       load      = done_r & ~full_r;
   wire logic       parity_error_flag_set  = done_r & RX_CFG.par_en &
                                par_bad(raw_r, n_data, RX_CFG.par_odd);
   wire logic       framing_error_flag_set  = done_r & m_uart & framing_error_flag_r;
   wire logic [2:0] stat_set  = {parity_error_flag_set, ovr, framing_error_flag_set};
   wire logic [2:0] stat_nxt  =
      (stat_r & ~{3{STATUS_RD}}) | stat_set;
   // a read that meets a new frame on a full buffer clears full; the frame is dropped as an overrun
   wire logic       full_nxt  = (full_r & ~RX_BUF_RD) | load;
   // software setting enable wins over the automatic clear
   wire logic       en_nxt    = RX_ENABLE_WR ? RX_ENABLE_WDATA :
                                (en_r & ~(irq_r & sync_r));

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         buf_r  <= `SPRX_BUF_RST;
         full_r <= 1'b0;
         stat_r <= `SPRX_STAT_RST;
         irq_r  <= 1'b0;
         sync_r <= 1'b0;
         en_r   <= 1'b0;
      end else begin
         if (load) begin
            buf_r <= assemble(raw_r, n_data, RX_CFG.msb_first);
         end
         full_r <= full_nxt;
         stat_r <= stat_nxt;
         irq_r  <= done_r;
         sync_r <= RX_CFG.mode_sync;
         en_r   <= en_nxt;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign RX_SHIFT_CLK_OUT = sck_r;
   assign RX_SHIFT_CLK_OE  = m_int & en_r;
   assign RX_ENABLE        = en_r;
   assign RX_DATA          = buf_r;
   assign RX_FULL          = full_r;
   assign RX_STATUS        = stat_r;
   assign RX_IRQ           = irq_r;
   assign RX_BUSY          = (st_r != sprx_pkg::SPRX_IDLE);

endmodule

`default_nettype wire

// *** hw/sprx_regs.svh ***
// sprx_regs.svh: constants of the serial port receive path
// assumes: included by bare name from the design
`ifndef SPRX_REGS_SVH
`define SPRX_REGS_SVH

// ****************************************
// status field positions
// ****************************************
`define SPRX_ST_FRAMING_ERROR_FLAG        0
`define SPRX_ST_OVERRUN_FLAG        1
`define SPRX_ST_PARITY_ERROR_FLAG        2

// ****************************************
// rate select codes
// ****************************************
`define SPRX_RATE_X2        2'h0
`define SPRX_RATE_X1        2'h1
`define SPRX_RATE_HALF      2'h2
`define SPRX_RATE_TMR       2'h3

// ****************************************
// format, reset values and timing counts
// ****************************************
`define SPRX_LEN_BASE       4'h5
`define SPRX_START_WAIT     2'h2
`define SPRX_BUF_RST        8'h00
`define SPRX_STAT_RST       3'h0

`endif

// *** hw/sprx_pkg.sv ***
// sprx_pkg.sv: types shared by the serial port receive path
// assumes: nothing beyond a SystemVerilog tool
`default_nettype none

package sprx_pkg;

   // ****************************************
   // receive format and mode, held by software
   // ****************************************
   typedef struct packed {
      logic       mode_sync;
      logic       clk_internal;
      logic       msb_first;
      logic [1:0] rate;
      logic [1:0] len;
      logic       par_en;
      logic       par_odd;
      logic       stop_two;
   } sprx_cfg_t;

   // ****************************************
   // serial status flags
   // ****************************************
   typedef struct packed {
      logic parity_err;
      logic overrun;
      logic framing_err;
   } sprx_stat_t;

   // ****************************************
   // receive sequencer states
   // ****************************************
   typedef enum logic [4:0] {
      SPRX_IDLE  = 5'h01,
      SPRX_UART  = 5'h02,
      SPRX_WAIT  = 5'h04,
      SPRX_SHIFT = 5'h08,
      SPRX_EXT   = 5'h10
   } sprx_state_t;

endpackage

`default_nettype wire

// *** testbench/sprx_top_properties.sv ***
// sprx_top_properties.sv: port-level checks of the serial port receive path
// assumes: bound to sprx_top; time base runs at 16 SYS_CLK cycles a period
`default_nettype none
module sprx_props #(
   parameter int DATA_W = 8
) (
   input wire logic                 SYS_CLK,
   input wire logic                 RST,
   input wire sprx_pkg::sprx_cfg_t  RX_CFG,
   input wire logic                 RX_ENABLE_WR,
   input wire logic                 RX_ENABLE_WDATA,
   input wire logic                 STATUS_RD,
   input wire logic                 RX_BUF_RD,
   input wire logic                 RX_SHIFT_CLK_OUT,
   input wire logic                 RX_SHIFT_CLK_OE,
   input wire logic                 RX_ENABLE,
   input wire logic [DATA_W-1:0]    RX_DATA,
   input wire logic                 RX_FULL,
   input wire sprx_pkg::sprx_stat_t RX_STATUS,
   input wire logic                 RX_IRQ,
   input wire logic                 RX_BUSY
);
   timeunit 1ns;
   timeprecision 100ps;
   // ****************************************
   // helper and assertions
   // ****************************************
   logic [7:0] en_cnt_r;
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   // cycles since enable; saturates so a long idle never wraps
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) en_cnt_r <= 8'h00;
      else if (!RX_ENABLE) en_cnt_r <= 8'h00;
      else if (en_cnt_r != 8'hff) en_cnt_r <= en_cnt_r + 8'h01;
   end
   sequence int_go;
      $rose(RX_ENABLE) && RX_CFG.mode_sync && RX_CFG.clk_internal;
   endsequence
   sequence sync_done;
      RX_IRQ && RX_CFG.mode_sync && !RX_ENABLE_WR ##1 !RX_ENABLE_WR;
   endsequence
   enable_write_a: assert property (RX_ENABLE_WR |=> RX_ENABLE == $past(RX_ENABLE_WDATA))
      else $error("enable write not taken");
   busy_gate_a: assert property ($rose(RX_BUSY) |-> RX_ENABLE)
      else $error("receive started while disabled");
   oe_mode_a: assert property (RX_SHIFT_CLK_OE == (RX_ENABLE && RX_CFG.mode_sync && RX_CFG.clk_internal))
      else $error("shift clock enable wrong for mode");
   start_early_a: assert property ($fell(RX_SHIFT_CLK_OUT) |-> en_cnt_r >= 8'd28)
      else $error("shift clock began too soon");
   start_late_a: assert property (int_go |-> ##[1:90] !RX_SHIFT_CLK_OUT)
      else $error("shift clock began too late");
   sck_rate_a: assert property ($rose(RX_SHIFT_CLK_OUT) && RX_SHIFT_CLK_OE |=> RX_SHIFT_CLK_OUT [*6])
      else $error("shift clock faster than time base");
   sck_idle_a: assert property ((!RX_SHIFT_CLK_OE) [*3] |-> RX_SHIFT_CLK_OUT)
      else $error("shift clock moved without internal mode");
   uart_keep_a: assert property (RX_IRQ && RX_ENABLE && !RX_CFG.mode_sync && !RX_ENABLE_WR |=> RX_ENABLE)
      else $error("uart enable dropped after frame");
   sync_clear_a: assert property (sync_done |=> !RX_ENABLE)
      else $error("sync enable not cleared");
   irq_full_a: assert property (RX_IRQ |-> RX_FULL)
      else $error("request before buffer load");
   irq_pulse_a: assert property (RX_IRQ |=> !RX_IRQ)
      else $error("request longer than one cycle");
   stat_clear_a: assert property (STATUS_RD && !RX_BUSY && !$past(RX_BUSY) |=> RX_STATUS == 3'h0)
      else $error("status read did not clear");
   stat_hold_a: assert property (RX_STATUS != 3'h0 && !STATUS_RD |=> (RX_STATUS & $past(RX_STATUS)) == $past(RX_STATUS))
      else $error("status flag lost without read");
   hold_full_a: assert property (RX_FULL && !RX_BUF_RD |=> $stable(RX_DATA))
      else $error("unread buffer overwritten");
endmodule
bind sprx_top sprx_props #(.DATA_W(DATA_W)) u_sprx_props (
   .SYS_CLK(SYS_CLK), .RST(RST), .RX_CFG(RX_CFG), .RX_ENABLE_WR(RX_ENABLE_WR),
   .RX_ENABLE_WDATA(RX_ENABLE_WDATA), .STATUS_RD(STATUS_RD), .RX_BUF_RD(RX_BUF_RD),
   .RX_SHIFT_CLK_OUT(RX_SHIFT_CLK_OUT), .RX_SHIFT_CLK_OE(RX_SHIFT_CLK_OE),
   .RX_ENABLE(RX_ENABLE), .RX_DATA(RX_DATA), .RX_FULL(RX_FULL), .RX_STATUS(RX_STATUS),
   .RX_IRQ(RX_IRQ), .RX_BUSY(RX_BUSY));
`default_nettype wire

// *** testbench/sprx_peer.sv ***
// sprx_peer.sv: far side, a remote transmitter and an external shift clock master
// assumes: the bench aligns uart frames to the receiver's rate ticks
`default_nettype none
module sprx_peer (
   input  wire logic ref_tb,
   input  wire logic ref_ovf,
   input  wire logic sck_out,
   output var  logic rxd,
   output var  logic sck_in
);
   timeunit 1ns;
   timeprecision 100ps;
   // ****************************************
   // frame drivers
   // ****************************************
   initial begin
      rxd = 1'b1;
      sck_in = 1'b1;
   end
   // bits change between ticks, midway except a quarter period in at half rate, so no sample races an edge
   task automatic send_uart(input logic [11:0] b, input int n, input int per, input int off,
                            input logic use_ovf);
      if (use_ovf) @(posedge ref_ovf);
      else @(posedge ref_tb);
      #(off);
      for (int i = 0; i < n; i++) begin
         rxd = b[i];
         #(per);
      end
      rxd = 1'b1;
   endtask
   task automatic send_int(input logic [8:0] b, input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge sck_out);
         rxd = b[i];
      end
      @(posedge sck_out);
      #20;
      rxd = ~b[n - 1];
   endtask
   // clock stands high between frames; released data shows the inverse
   task automatic send_ext(input logic [8:0] b, input int n);
      repeat (6) @(posedge ref_tb);
      for (int i = 0; i < n; i++) begin
         sck_in = 1'b0;
         rxd = b[i];
         #3;
         sck_in = 1'b1;
         #3;
      end
      rxd = ~b[n - 1];
   endtask
endmodule
`default_nettype wire

// *** testbench/serial_port_receiver_tb_top.sv ***
// serial_port_receiver_tb_top.sv: self-checking bench of the receive path
// assumes: sprx_top with default parameters, sprx_peer as the far side
`default_nettype none
`define SPRX_CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
   $display("mismatch at %0t: got %0h want %0h", $time, g, e); end end
module serial_port_receiver_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   // ****************************************
   // signals, clocks and scoreboard
   // ****************************************
   logic sys_clk, rst, wr, wdata, srd, brd, tb_clk, rxd, sck_in, sck_out, sck_oe, en, full;
   logic irq, busy;
   logic ovf = 1'b0;
   logic [7:0] data, last;
   logic [10:0] got;
   sprx_pkg::sprx_cfg_t cfg;
   sprx_pkg::sprx_stat_t stat;
   int fail_count = 0, n_checks = 0, cyc = 0, irq_cnt = 0;
   logic [10:0] exp_q[$];
   sprx_top u_sprx_top (
      .SYS_CLK(sys_clk), .RST(rst), .RX_CFG(cfg), .RX_ENABLE_WR(wr), .RX_ENABLE_WDATA(wdata),
      .STATUS_RD(srd), .RX_BUF_RD(brd), .TIME_BASE_CLK(tb_clk), .TIMER_OVF(ovf), .RXD(rxd),
      .RX_SHIFT_CLK_IN(sck_in), .RX_SHIFT_CLK_OUT(sck_out), .RX_SHIFT_CLK_OE(sck_oe),
      .RX_ENABLE(en), .RX_DATA(data), .RX_FULL(full), .RX_STATUS(stat), .RX_IRQ(irq),
      .RX_BUSY(busy));
   sprx_peer u_sprx_peer (
      .ref_tb(tb_clk), .ref_ovf(ovf), .sck_out(sck_out), .rxd(rxd), .sck_in(sck_in));
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   initial begin
      tb_clk = 1'b0;
      #1;
      forever #32 tb_clk = ~tb_clk;
   end
   // timer tick every 16 cycles; ceiling well above the few thousand cycles needed
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      ovf <= #1 (cyc % 16 == 15);
      if (cyc == 40000) begin
         fail_count++;
         stop_test();
      end
   end
   always @(negedge sys_clk) begin
      if (irq === 1'b1) begin
         irq_cnt++;
         got = (exp_q.size() > 0) ? exp_q.pop_front() : 11'h7ff;
         `SPRX_CHK(data, got[10:3])
         `SPRX_CHK(stat, got[2:0])
      end
   end
   // ****************************************
   // tasks
   // ****************************************
   task automatic stop_test();
      if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic tick();
      @(posedge sys_clk);
      #1;
   endtask
   task automatic set_en(input logic v);
      tick();
      wr = 1'b1;
      wdata = v;
      tick();
      wr = 1'b0;
   endtask
   task automatic clr();
      tick();
      srd = 1'b1;
      brd = 1'b1;
      tick();
      srd = 1'b0;
      brd = 1'b0;
   endtask
   task automatic wait_irq();
      int c0, i;
      c0 = irq_cnt;
      i = 0;
      while (irq_cnt == c0 && i < 2000) begin
         @(negedge sys_clk);
         i++;
      end
      `SPRX_CHK(irq_cnt, c0 + 1)
   endtask
   // data bits in line order, parity placed after them; unused buffer bits stay 0
   task automatic mk(input logic bad_par, output logic [8:0] db, output int nb,
                     output logic [7:0] e);
      int n;
      n = 5 + int'(cfg.len);
      e = 8'($urandom);
      e = cfg.msb_first ? (e & ~(8'hff >> n)) : (e & ((8'h01 << n) - 8'h01));
      db = 9'h000;
      for (int k = 0; k < n; k++) db[k] = cfg.msb_first ? e[7 - k] : e[k];
      db[n] = (^e) ^ cfg.par_odd ^ bad_par;
      nb = n + int'(cfg.par_en);
   endtask
   task automatic uart_frame(input logic bad_par, input logic bad_stop, input logic ovr,
                             input logic rd);
      logic [8:0] db;
      logic [7:0] e;
      logic [11:0] b;
      int nb, per;
      mk(bad_par, db, nb, e);
      if (!ovr) last = e;
      exp_q.push_back({last, cfg.par_en & bad_par, ovr, bad_stop});
      b = 12'hfff;
      b[0] = 1'b0;
      for (int k = 0; k < nb; k++) b[k + 1] = db[k];
      b[nb + 1] = ~bad_stop;
      per = (cfg.rate == 2'h0) ? 32 : ((cfg.rate == 2'h2) ? 128 : 64);
      fork
         u_sprx_peer.send_uart(b, nb + 2 + int'(cfg.stop_two), per, (per == 32) ? 16 : 32,
                               cfg.rate == 2'h3);
         wait_irq();
      join
      if (rd) clr();
   endtask
   task automatic sync_frame(input logic intl);
      logic [8:0] db;
      logic [7:0] e;
      int nb;
      cfg = 10'($urandom);
      cfg.mode_sync = 1'b1;
      cfg.clk_internal = intl;
      cfg.par_en = 1'b1;
      mk(intl, db, nb, e);
      exp_q.push_back({e, intl, 1'b0, 1'b0});
      set_en(1'b1);
      fork
         if (intl) u_sprx_peer.send_int(db, nb);
         else u_sprx_peer.send_ext(db, nb);
         wait_irq();
      join
      repeat (2) tick();
      `SPRX_CHK(en, 1'b0)
      clr();
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      int c0;
      cfg = '0;
      wr = 1'b0;
      wdata = 1'b0;
      srd = 1'b0;
      brd = 1'b0;
      rst = 1'b1;
      repeat (5) @(posedge sys_clk);
      #1;
      rst = 1'b0;
      repeat (4) tick();
      void'($urandom(60));
      for (int i = 0; i < 4; i++) begin
         cfg = 10'($urandom);
         cfg.mode_sync = 1'b0;
         cfg.rate = 2'(i);
         cfg.par_en = cfg.par_en | i[0];
         set_en(1'b1);
         uart_frame(1'b0, 1'b0, 1'b0, 1'b1);
         uart_frame(i[0], i[1], 1'b0, 1'b1);
         set_en(1'b0);
      end
      cfg.rate = 2'h1;
      set_en(1'b1);
      uart_frame(1'b0, 1'b0, 1'b0, 1'b0);
      uart_frame(1'b0, 1'b0, 1'b1, 1'b1);
      set_en(1'b0);
      c0 = irq_cnt;
      u_sprx_peer.send_uart(12'hca4, 12, 64, 32, 1'b0);
      repeat (10) tick();
      `SPRX_CHK(irq_cnt, c0)
      sync_frame(1'b1);
      sync_frame(1'b0);
      `SPRX_CHK(exp_q.size(), 0)
      stop_test();
   end
endmodule
`default_nettype wire
